// ---- rtl/lpc_pkg.sv ----
// Package for the low-power wait/stop controller: register map, fields, states, timing.
// Assumes a 50 MHz core clock and a 32-bit APB slave port.
package lpc_pkg;
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned OSC_DELAY_US    = 100;
  localparam int unsigned OSC_DELAY_CYC   = OSC_DELAY_US * CLK_MHZ;
  localparam int unsigned DLY_W           = 16;
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STAT       = 12'h004;
  localparam logic [11:0] ADDR_CNT        = 12'h008;
  localparam int unsigned CTRL_DLY_BIT    = 0;
  localparam int unsigned CTRL_WDOG_BIT   = 1;
  localparam int unsigned CTRL_SYNC_BIT   = 2;
  localparam int unsigned CTRL_TX_BIT     = 3;
  localparam int unsigned CTRL_RX_BIT     = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h01;
  localparam logic [7:0]  CCR_S_BIT       = 8'h80;
  localparam logic [7:0]  CCR_X_BIT       = 8'h40;
  localparam logic [7:0]  CCR_I_BIT       = 8'h10;
  localparam int unsigned SYNC_STAGES     = 3;

  typedef enum logic [2:0] {
    LPC_RUN      = 3'b000,
    LPC_STACK    = 3'b001,
    LPC_WAIT     = 3'b010,
    LPC_STOP     = 3'b011,
    LPC_OSC_WAIT = 3'b100,
    LPC_RESUME   = 3'b101
  } lpc_state_e;
endpackage : lpc_pkg

// ---- rtl/lpc_delay_if.sv ----
// Handshake bundle between the sequencer and the oscillator delay counter.
// Assumes both ends share clock_in.
`timescale 1ns/100ps
`default_nettype none
interface lpc_delay_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport cnt  (input start, output done);
endinterface : lpc_delay_if
`default_nettype wire

// ---- rtl/lpc_delay_cnt.sv ----
// Oscillator stabilisation counter: loads on start, pulses done on expiry.
// Assumes start is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module lpc_delay_cnt
  import lpc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = OSC_DELAY_CYC
) (
  input  wire logic  clock_in,
  input  wire logic  rst_n_in,
  lpc_delay_if.cnt   dl,
  output logic [DLY_W-1:0] count_out
);
  logic [DLY_W-1:0] cnt_q;
  logic             busy_q;
  logic             done_q;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (dl.start) begin
        cnt_q  <= DLY_W'(DELAY_CYC - 1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign dl.done   = done_q;
  assign count_out = cnt_q;
endmodule : lpc_delay_cnt
`default_nettype wire

// ---- rtl/lpc_ctrl.sv ----
// Low-power wait/stop sequencer with APB control registers.
// Assumes the CPU core pulses the opcodes and supplies its condition codes.
// Functional notes
// - Wait opcode stacks registers, then suspends CPU until unmasked interrupt.
// - Oscillator keeps running during wait; CPU always halted.
// - While waiting, bus repeatedly reads the stacked condition-code address.
// - Any unmasked interrupt except a pending edge ends wait: pin level, nonmaskable pin, timer, serial.
// - Timer stops in wait only when I mask and watchdog disable set.
// - Serial and UART clocks in wait follow their own enable bits.
// - Stop opcode enters stop only with stop-disable bit clear, else no-op.
// - Stop halts all clocks including oscillator.
// - Low pin level, reset, or pending edge interrupt ends stop.
// - Stop keeps CPU state and pin levels; interrupt wake resumes normally.
// - Reset exit from stop runs the normal reset sequence.
// - Maskable pin wakes stop only when I mask clear.
// - Nonmaskable pin always wakes stop, wait only with X clear; X clear services, X set continues.
// - Stabilisation delay on stop exit unless delay-enable bit cleared.
// - Delay always after power-on reset, never after running reset.
// - RAM contents preserved through stop and wait.
// - Servicing sets I after stacking; nonmaskable sets X and I.
`timescale 1ns/100ps
`default_nettype none
module lpc_ctrl
  import lpc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = OSC_DELAY_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        por_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        wait_for_interrupt_opcode_in,
  input  wire logic        stop_opcode_in,
  input  wire logic [7:0]  condition_code_register_in,
  input  wire logic        stack_done_in,
  input  wire logic [15:0] ccr_stack_addr_in,
  input  wire logic        maskable_int_n_in,
  input  wire logic        nonmaskable_int_pin_n_in,
  input  wire logic        edge_irq_pending_in,
  input  wire logic        internal_int_in,
  output logic             stack_req_out,
  output logic             cpu_halt_out,
  output logic             osc_enable_out,
  output logic             clocks_enable_out,
  output logic             timer_clk_en_out,
  output logic             sync_serial_clk_en_out,
  output logic             uart_tx_clk_en_out,
  output logic             uart_rx_clk_en_out,
  output logic             bus_read_out,
  output logic [15:0]      bus_addr_out,
  output logic             vector_fetch_out,
  output logic             skip_stack_out,
  output logic             set_i_out,
  output logic             set_x_out,
  output logic             pin_hold_out,
  output logic [2:0]       state_out
);
  lpc_state_e  st_q;
  lpc_delay_if dl ();
  logic [DLY_W-1:0] cnt_w;
  logic [4:0]  ctrl_q;
  logic [SYNC_STAGES-1:0] irq_s_q;
  logic [SYNC_STAGES-1:0] nonmaskable_int_pin_s_q;
  logic        irq_lo_q;
  logic        nonmaskable_int_pin_lo_q;
  logic        por_q;
  logic        boot_q;
  logic        stop_mem_q;
  logic        from_wait_q;
  logic        xserv_q;
  logic        start_q;
  logic [31:0] rdata_q;

  function automatic logic agree_low(input logic [SYNC_STAGES-1:0] s);
    agree_low = (s[1] == s[2]) ? !s[2] : 1'b0;
  endfunction : agree_low

  // Three-stage pin synchronisers; only stages two and three are compared
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_s_q   <= '1;
      nonmaskable_int_pin_s_q  <= '1;
      irq_lo_q  <= 1'b0;
      nonmaskable_int_pin_lo_q <= 1'b0;
    end else begin
      irq_s_q   <= {irq_s_q[1:0], maskable_int_n_in};
      nonmaskable_int_pin_s_q  <= {nonmaskable_int_pin_s_q[1:0], nonmaskable_int_pin_n_in};
      if (irq_s_q[1] == irq_s_q[2])
        irq_lo_q <= agree_low(irq_s_q);
      if (nonmaskable_int_pin_s_q[1] == nonmaskable_int_pin_s_q[2])
        nonmaskable_int_pin_lo_q <= agree_low(nonmaskable_int_pin_s_q);
    end
  end

  logic i_mask;
  logic x_mask;
  logic wait_wake;
  logic stop_wake;
  assign i_mask = |(condition_code_register_in & CCR_I_BIT);
  assign x_mask = |(condition_code_register_in & CCR_X_BIT);
  assign wait_wake = ((irq_lo_q || internal_int_in) && !i_mask) || (nonmaskable_int_pin_lo_q && !x_mask);
  assign stop_wake = (irq_lo_q && !i_mask) || (edge_irq_pending_in && !i_mask) || nonmaskable_int_pin_lo_q;

  // Reset-delay flag: a reset that must wait for the oscillator, cleared once served
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      por_q <= 1'b0;
    else if (boot_q && (por_in || stop_mem_q))
      por_q <= 1'b1;
    else if (dl.done)
      por_q <= 1'b0;
  end

  // APB register file; zero wait states
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in &&
                       !(paddr_in == ADDR_CTRL || paddr_in == ADDR_STAT || paddr_in == ADDR_CNT);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ctrl_q <= CTRL_RESET;
    else if (wr_en && paddr_in == ADDR_CTRL)
      ctrl_q <= pwdata_in[4:0];
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rdata_q <= '0;
    else if (rd_en) begin
      case (paddr_in)
        ADDR_CTRL: rdata_q <= {27'h0, ctrl_q};
        ADDR_STAT: rdata_q <= {28'h0000000, por_q, st_q};
        ADDR_CNT:  rdata_q <= {16'h0000, cnt_w};
        default:   rdata_q <= '0;
      endcase
    end
  end
  assign prdata_out = rdata_q;

  // Sequencer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q        <= LPC_OSC_WAIT;
      from_wait_q <= 1'b0;
      xserv_q     <= 1'b0;
      start_q     <= 1'b0;
      boot_q      <= 1'b1;
    end else begin
      start_q <= 1'b0;
      boot_q  <= 1'b0;
      case (st_q)
        LPC_RUN: begin
          from_wait_q <= 1'b0;
          xserv_q     <= 1'b0;
          if (wait_for_interrupt_opcode_in)
            st_q <= LPC_STACK;
          else if (stop_opcode_in && !(|(condition_code_register_in & CCR_S_BIT)))
            st_q <= LPC_STOP;
        end
        LPC_STACK: if (stack_done_in) st_q <= LPC_WAIT;
        LPC_WAIT: begin
          if (wait_wake) begin
            st_q        <= LPC_RESUME;
            from_wait_q <= 1'b1;
            xserv_q     <= nonmaskable_int_pin_lo_q && !x_mask;
          end
        end
        LPC_STOP: begin
          if (stop_wake) begin
            xserv_q <= nonmaskable_int_pin_lo_q && !x_mask;
            if (ctrl_q[CTRL_DLY_BIT]) begin
              st_q    <= LPC_OSC_WAIT;
              start_q <= 1'b1;
            end else
              st_q <= LPC_RESUME;
          end
        end
        LPC_OSC_WAIT: begin
          if (boot_q) begin
            // delay after power-on or a reset out of stop only
            if (por_in || stop_mem_q)
              start_q <= 1'b1;
            else
              st_q <= LPC_RUN;
          end else if (dl.done)
            st_q <= (por_q || !stop_wake) ? LPC_RUN : LPC_RESUME;
        end
        LPC_RESUME: st_q <= LPC_RUN;
        default: st_q <= LPC_RUN;
      endcase
    end
  end

  assign dl.start = start_q;

  lpc_delay_cnt #(
    .DELAY_CYC (DELAY_CYC)
  ) u_dly (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .dl        (dl),
    .count_out (cnt_w)
  );

  logic in_wait;
  logic in_stop;
  assign in_wait = (st_q == LPC_WAIT);
  assign in_stop = (st_q == LPC_STOP) || (st_q == LPC_OSC_WAIT);

  // Held while in reset: a reset out of stop still owes the oscillator delay
  always_ff @(posedge clock_in) begin
    if (rst_n_in)
      stop_mem_q <= in_stop;
  end

  // halt CPU, oscillator on in wait
  assign cpu_halt_out      = (st_q != LPC_RUN);
  assign stack_req_out     = (st_q == LPC_STACK);
  // oscillator and clocks off in stop; RAM keeps supply
  assign osc_enable_out    = (st_q != LPC_STOP);
  assign clocks_enable_out = !in_stop;
  assign timer_clk_en_out  = !in_stop && !(in_wait && i_mask && ctrl_q[CTRL_WDOG_BIT]);
  assign sync_serial_clk_en_out = !in_stop && (!in_wait || ctrl_q[CTRL_SYNC_BIT]);
  assign uart_tx_clk_en_out     = !in_stop && (!in_wait || ctrl_q[CTRL_TX_BIT]);
  assign uart_rx_clk_en_out     = !in_stop && (!in_wait || ctrl_q[CTRL_RX_BIT]);
  assign bus_read_out  = in_wait;
  assign bus_addr_out  = in_wait ? ccr_stack_addr_in : 16'h0000;
  // pins frozen in stop and oscillator wait, which rst_n_in low also loads
  assign pin_hold_out  = in_stop;
  assign vector_fetch_out = (st_q == LPC_RESUME) && (from_wait_q || xserv_q
                            || (!i_mask && (irq_lo_q || edge_irq_pending_in)));
  assign skip_stack_out   = (st_q == LPC_RESUME) && from_wait_q;
  assign set_i_out        = vector_fetch_out;
  assign set_x_out        = vector_fetch_out && xserv_q;
  assign state_out        = st_q;

  stop_nop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st_q == LPC_RUN && stop_opcode_in && !wait_for_interrupt_opcode_in && !por_in
     && |(condition_code_register_in & CCR_S_BIT)) |=> st_q != LPC_STOP)
    else $error("stop entered with S set");
  stop_osc_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    st_q == LPC_STOP |-> !osc_enable_out && !clocks_enable_out)
    else $error("clocks running in stop");
  wait_osc_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    in_wait |-> osc_enable_out && cpu_halt_out)
    else $error("oscillator off in wait");
  wait_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    in_wait |-> bus_read_out && bus_addr_out == ccr_stack_addr_in)
    else $error("no dummy read in wait");
  timer_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (in_wait && !i_mask) |-> timer_clk_en_out)
    else $error("timer stopped while I clear");
  wait_exit_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (in_wait && wait_wake) |=> st_q == LPC_RESUME ##1 st_q == LPC_RUN)
    else $error("wait not left on interrupt");
  irq_mask_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st_q == LPC_STOP && i_mask && !nonmaskable_int_pin_lo_q) |=> st_q == LPC_STOP)
    else $error("masked pin woke stop");
  dly_skip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (st_q == LPC_STOP && stop_wake && !ctrl_q[CTRL_DLY_BIT]) |=> st_q == LPC_RESUME)
    else $error("delay applied while disabled");
  stack_first_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(in_wait) |-> $past(st_q) == LPC_STACK)
    else $error("wait without stacking");
  por_dly_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (boot_q && por_in) |=> start_q && st_q == LPC_OSC_WAIT)
    else $error("no delay after power-on");
  run_rst_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (boot_q && !por_in && !stop_mem_q) |=> st_q == LPC_RUN)
    else $error("delay after running reset");
  serial_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    in_wait |-> uart_tx_clk_en_out == ctrl_q[CTRL_TX_BIT]
      && uart_rx_clk_en_out == ctrl_q[CTRL_RX_BIT])
    else $error("serial clock not per enable in wait");
  nmi_flags_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    set_x_out |-> set_i_out)
    else $error("X set without I");
  cv_boot: cover property (@(posedge clock_in) disable iff (!rst_n_in) boot_q && stop_mem_q);
  cv_wait: cover property (@(posedge clock_in) disable iff (!rst_n_in) in_wait ##1 !in_wait);
  cv_stop: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    st_q == LPC_STOP ##1 st_q == LPC_OSC_WAIT);
  cv_fast: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    st_q == LPC_STOP ##1 st_q == LPC_RESUME);
endmodule : lpc_ctrl
`default_nettype wire

// ---- tb/lpc_cpu_model.sv ----
// CPU core stand-in: answers each stacking request with a one-cycle done pulse.
// Assumes the sequencer holds its stacking request until done is seen.
`timescale 1ns/100ps
`default_nettype none
module lpc_cpu_model #(
  parameter int unsigned STACK_CYC = 4
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic stack_req_in,
  output logic      stack_done_out
);
  logic [3:0] cnt_q;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q          <= 4'h0;
      stack_done_out <= 1'b0;
    end else if (stack_req_in && !stack_done_out) begin
      // A real core needs several cycles to push the registers
      cnt_q          <= (cnt_q == 4'(STACK_CYC - 1)) ? 4'h0 : cnt_q + 4'h1;
      stack_done_out <= (cnt_q == 4'(STACK_CYC - 1));
    end else begin
      cnt_q          <= 4'h0;
      stack_done_out <= 1'b0;
    end
  end
endmodule : lpc_cpu_model
`default_nettype wire

// ---- tb/tb_low_power_wait_stop_control.sv ----
// Testbench for the low-power wait/stop controller: registers, wait and stop.
// Assumes lpc_pkg, the delay interface and counter, and lpc_ctrl compile first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module tb_low_power_wait_stop_control;
  import lpc_pkg::*;
  localparam int unsigned DLY = 8;
  localparam logic [15:0] CCR_ADDR = 16'h01F7;
  logic clock_in, rst_n_in, por_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic wait_for_interrupt_opcode_in, stop_opcode_in, stack_done_in, maskable_int_n_in;
  logic nonmaskable_int_pin_n_in, edge_irq_pending_in, internal_int_in, stack_req_out;
  logic [7:0] condition_code_register_in;
  logic [15:0] ccr_stack_addr_in, bus_addr_out;
  logic cpu_halt_out, osc_enable_out, clocks_enable_out, timer_clk_en_out, bus_read_out;
  logic sync_serial_clk_en_out, uart_tx_clk_en_out, uart_rx_clk_en_out, vector_fetch_out;
  logic skip_stack_out, set_i_out, set_x_out, pin_hold_out;
  logic [2:0] state_out;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  lpc_ctrl #(.DELAY_CYC(DLY)) dut_u (
    .clock_in, .rst_n_in, .por_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .wait_for_interrupt_opcode_in, .stop_opcode_in,
    .condition_code_register_in, .stack_done_in, .ccr_stack_addr_in, .maskable_int_n_in,
    .nonmaskable_int_pin_n_in, .edge_irq_pending_in, .internal_int_in, .stack_req_out,
    .cpu_halt_out, .osc_enable_out, .clocks_enable_out, .timer_clk_en_out,
    .sync_serial_clk_en_out, .uart_tx_clk_en_out, .uart_rx_clk_en_out, .bus_read_out,
    .bus_addr_out, .vector_fetch_out, .skip_stack_out, .set_i_out, .set_x_out,
    .pin_hold_out, .state_out);

  lpc_cpu_model cpu_u (.clock_in, .rst_n_in, .stack_req_in(stack_req_out),
    .stack_done_out(stack_done_in));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Whole run needs a few hundred cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clock_in);
    penable_in <= 1'b1;
    // Answer taken at the rising edge that sees pready high
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wait_st(input logic [2:0] st, output int n);
    n = 0;
    while (state_out !== st && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    `CHK("state", st, state_out)
  endtask : wait_st

  task automatic pulse(input bit stop);
    @(posedge clock_in);
    if (stop) stop_opcode_in <= 1'b1;
    else wait_for_interrupt_opcode_in <= 1'b1;
    @(posedge clock_in);
    stop_opcode_in <= 1'b0;
    wait_for_interrupt_opcode_in <= 1'b0;
    #1;
  endtask : pulse

  task automatic do_reset;
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  task automatic idle_pins;
    @(posedge clock_in);
    maskable_int_n_in <= 1'b1;
    nonmaskable_int_pin_n_in <= 1'b1;
    edge_irq_pending_in <= 1'b0;
    internal_int_in <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask : idle_pins

  task automatic t_regs;
    logic [31:0] rd;
    logic er;
    apb(0, ADDR_CTRL, 32'h0, rd, er);
    `CHK("ctrl_rst", 32'h1, rd)
    apb(0, 12'h00C, 32'h0, rd, er);
    `CHK("unmapped", 1'b1, er)
    apb(1, ADDR_CTRL, 32'h1F, rd, er);
    apb(0, ADDR_CTRL, 32'h0, rd, er);
    `CHK("ctrl_rw", 32'h1F, rd)
  endtask : t_regs

  task automatic t_wait(input logic [7:0] condition_code_register, input logic [4:0] ctl, input bit nmi);
    logic [31:0] rd;
    logic er;
    int n;
    apb(1, ADDR_CTRL, {27'h0, ctl}, rd, er);
    @(posedge clock_in);
    condition_code_register_in <= condition_code_register;
    pulse(0);
    `CHK("stack_req", 1'b1, stack_req_out)
    wait_st(LPC_WAIT, n);
    `CHK("halt", 1'b1, cpu_halt_out)
    `CHK("osc", 1'b1, osc_enable_out)
    `CHK("bus_read", 1'b1, bus_read_out)
    `CHK("bus_addr", CCR_ADDR, bus_addr_out)
    `CHK("timer", !(condition_code_register[4] && ctl[1]), timer_clk_en_out)
    `CHK("sync", ctl[2], sync_serial_clk_en_out)
    `CHK("tx", ctl[3], uart_tx_clk_en_out)
    `CHK("rx", ctl[4], uart_rx_clk_en_out)
    @(posedge clock_in);
    if (nmi) nonmaskable_int_pin_n_in <= 1'b0;
    else internal_int_in <= 1'b1;
    wait_st(LPC_RESUME, n);
    `CHK("skip", 1'b1, skip_stack_out)
    `CHK("vector", 1'b1, vector_fetch_out)
    `CHK("set_i", 1'b1, set_i_out)
    `CHK("set_x", nmi, set_x_out)
    idle_pins();
    wait_st(LPC_RUN, n);
  endtask : t_wait

  task automatic t_stop(input logic [7:0] condition_code_register, input logic [4:0] ctl, input int src);
    logic [31:0] rd;
    logic er;
    int n;
    apb(1, ADDR_CTRL, {27'h0, ctl}, rd, er);
    @(posedge clock_in);
    condition_code_register_in <= condition_code_register;
    pulse(1);
    `CHK("state", condition_code_register[7] ? LPC_RUN : LPC_STOP, state_out)
    if (condition_code_register[7]) return;
    `CHK("osc", 1'b0, osc_enable_out)
    `CHK("clocks", 1'b0, clocks_enable_out)
    `CHK("hold", 1'b1, pin_hold_out)
    `CHK("timer_stop", 1'b0, timer_clk_en_out)
    if (condition_code_register[4]) begin
      @(posedge clock_in);
      maskable_int_n_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      #1;
      `CHK("masked", LPC_STOP, state_out)
      idle_pins();
    end
    @(posedge clock_in);
    if (src == 0) maskable_int_n_in <= 1'b0;
    else if (src == 1) nonmaskable_int_pin_n_in <= 1'b0;
    else edge_irq_pending_in <= 1'b1;
    if (ctl[0]) begin
      wait_st(LPC_OSC_WAIT, n);
      wait_st(LPC_RESUME, n);
      // Start and done pulses each add a cycle
      `CHK("delay", DLY + 2, n)
    end else wait_st(LPC_RESUME, n);
    `CHK("vector", src != 1 || !condition_code_register[6], vector_fetch_out)
    `CHK("set_x", src == 1 && !condition_code_register[6], set_x_out)
    idle_pins();
    wait_st(LPC_RUN, n);
  endtask : t_stop

  task automatic t_reset_in_stop;
    logic [31:0] rd;
    logic er;
    int n;
    t_stop(8'h80, 5'h00, 0);
    @(posedge clock_in);
    condition_code_register_in <= 8'h00;
    pulse(1);
    @(posedge clock_in);
    do_reset();
    #1;
    `CHK("osc", 1'b1, osc_enable_out)
    wait_st(LPC_RUN, n);
    // Boot cycle, start pulse and done pulse add three cycles
    `CHK("stop_rst_dly", DLY + 3, n)
    apb(0, ADDR_CTRL, 32'h0, rd, er);
    `CHK("ctrl_rst", 32'h1, rd)
  endtask : t_reset_in_stop

  task automatic t_run_reset;
    int n;
    @(posedge clock_in);
    do_reset();
    wait_st(LPC_RUN, n);
    `CHK("run_rst", 1, n)
  endtask : t_run_reset

  initial begin
    int n;
    rst_n_in = 1'b0;
    por_in = 1'b1;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {wait_for_interrupt_opcode_in, stop_opcode_in, edge_irq_pending_in, internal_int_in} = '0;
    {maskable_int_n_in, nonmaskable_int_pin_n_in} = 2'b11;
    condition_code_register_in = 8'h50;
    ccr_stack_addr_in = CCR_ADDR;
    do_reset();
    wait_st(LPC_RUN, n);
    `CHK("por_delay", DLY + 3, n)
    por_in <= 1'b0;
    t_regs();
    t_wait(8'h10, 5'h0B, 1);
    t_wait(8'h40, 5'h15, 0);
    t_stop(8'h10, 5'h01, 1);
    t_stop(8'h00, 5'h01, 0);
    t_stop(8'h40, 5'h00, 1);
    t_stop(8'h00, 5'h00, 1);
    t_stop(8'h00, 5'h00, 2);
    t_run_reset();
    t_reset_in_stop();
    print_verdict();
  end
endmodule : tb_low_power_wait_stop_control
`default_nettype wire
